// ### logic/dps_map.svh
// dps_map.svh: bit positions, counts and defaults of the ddr psram link
// assumes: included by bare name from logic/
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_CA_BYTES 6
`define DPS_CA_CYC 3
`define DPS_CA_RNW 47
`define DPS_CA_SPACE 46
`define DPS_CA_LINEAR 45
`define DPS_CA_ROW_HI 44
`define DPS_CA0_LSB 32
`define DPS_COL_BITS 3
`define DPS_RSVD_BITS 13
`define DPS_LAT_CYC 6
`define DPS_DIE_AW 10
`define DPS_WRAP_LOG2 4
`define DPS_HALF_CLK 4
`define DPS_LAT_SAMPLE_EDGE 2
`endif

// ### logic/dps_pkg.sv
// dps_pkg: state types of both link ends
// assumes: nothing beyond a SystemVerilog compiler
package dps_pkg;
   typedef enum logic [1:0] {
      DPS_DEV_CMD = 2'b00,
      DPS_DEV_LAT = 2'b01,
      DPS_DEV_DATA = 2'b10
   } dps_dev_st_t;
   typedef enum logic [1:0] {
      DPS_HST_IDLE = 2'b00,
      DPS_HST_RUN = 2'b01,
      DPS_HST_STOP = 2'b10
   } dps_hst_st_t;
endpackage

// ### logic/dps_link_if.sv
// dps_link_if: pins between host end and memory end
// assumes: two-way pins resolved here from the output enables
`timescale 1ns/1ps
interface dps_link_if;
   logic ck;
   logic ckN;
   logic csN;
   logic hwRstN;
   logic [7:0] dqH;
   logic dqHOe;
   logic [7:0] dqD;
   logic dqDOe;
   logic [7:0] dq;
   logic rwdsH;
   logic rwdsHOe;
   logic rwdsD;
   logic rwdsDOe;
   logic read_write_strobe;
   // memory end wins when both drive; host value stands in for the pull
   assign dq = dqDOe ? dqD : dqH;
   assign read_write_strobe = rwdsDOe ? rwdsD : rwdsH;
   modport host(output ck, ckN, csN, hwRstN, dqH, dqHOe, rwdsH, rwdsHOe, input dq, read_write_strobe);
   modport dev(input ck, ckN, csN, hwRstN, dq, read_write_strobe, output dqD, dqDOe, rwdsD, rwdsDOe);
endinterface

// ### logic/dps_dev_end.sv
// dps_dev_end: memory end of the ddr psram link, with a small flop array
// assumes: host makes ck and frames it with csN; clk is a free system clock
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_dev_end #(
   parameter int AW = `DPS_DIE_AW,
   parameter int WRAP_LOG2 = `DPS_WRAP_LOG2,
   parameter int LAT = `DPS_LAT_CYC
) (
   // link pins
   dps_link_if.dev lnk,
   // system side
   input wire logic clk,
   input wire logic arst_n,
   // refresh request and package strap
   input wire logic refreshReq,
   input wire logic dualDie,
   // status
   output logic busy
);
   localparam int DEPTH = 1 << AW;
   localparam logic [7:0] LAST1 = 8'(`DPS_CA_CYC + LAT - 1);
   localparam logic [7:0] LAST2 = 8'(`DPS_CA_CYC + 2 * LAT - 1);
   localparam int ROWW = `DPS_CA_ROW_HI - `DPS_CA0_LSB + 1;

   logic linkRst_n;
   logic refS1_q;
   logic refS2_q;
   logic csS1_q;
   logic busy_q;
   // rising-edge group
   logic [7:0] hiQ_q, hiQ_d;
   logic [7:0] loHold_q, loHold_d;
   logic mskA_q, mskA_d;
   logic extra_q, extra_d;
   logic started_q, started_d;
   logic [8:0] posQ_q, posQ_d;
   // falling-edge group
   dps_pkg::dps_dev_st_t st_q, st_d;
   logic [7:0] cyc_q, cyc_d;
   logic [ROWW-1:0] caTop_q, caTop_d;
   logic [15:0] caMid_q, caMid_d;
   logic rnw_q, rnw_d;
   logic space_q, space_d;
   logic lin_q, lin_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [8:0] negQ_q, negQ_d;
   logic [15:0] mem_q [DEPTH];
   logic [15:0] mem_d [DEPTH];
   logic [AW-1:0] addrNext;
   logic [15:0] word;
   logic [15:0] rdWord;
   logic [31:0] fullAddr;
   logic extraNow;
   logic rdData;
   logic latShown;

   // a frame ends with select high and no further edge, so select resets
   assign linkRst_n = lnk.hwRstN & ~lnk.csN;

   // refresh request crosses into the link clock
   always_ff @(posedge lnk.ck or negedge lnk.hwRstN) begin
      if (!lnk.hwRstN) begin
         refS1_q <= 1'b0;
         refS2_q <= 1'b0;
      end else begin
         refS1_q <= refreshReq;
         refS2_q <= refS1_q;
      end
   end

   // select level crosses back into clk for status
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         csS1_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         csS1_q <= ~lnk.csN;
         busy_q <= csS1_q;
      end
   end
   assign busy = busy_q;

   assign extraNow = dualDie | refS2_q;
   assign latShown = started_q ? extra_q : extraNow;
   // byte A on the rising edge, byte B on the falling one
   assign word = {hiQ_q, lnk.dq};
   // register space is not modelled: reads give zero, writes are dropped
   assign rdWord = space_q ? 16'h0000 : mem_q[addr_q];
   assign rdData = (st_q == dps_pkg::DPS_DEV_DATA) && rnw_q;
   assign fullAddr = {caTop_q, caMid_q, word[`DPS_COL_BITS-1:0]};

   // flop array is read in the same cycle, so row ends never stall
   always_comb begin
      addrNext = addr_q + 1'b1;
      if (!lin_q) begin
         addrNext = {addr_q[AW-1:WRAP_LOG2], addrNext[WRAP_LOG2-1:0]};
      end
   end

   // complement clock is ignored, a single-ended ck suffices
   always_comb begin
      hiQ_d = lnk.dq;
      mskA_d = lnk.read_write_strobe;
      started_d = 1'b1;
      extra_d = latShown;
      posQ_d = posQ_q;
      loHold_d = loHold_q;
      if (rdData) begin
         posQ_d = {1'b1, rdWord[15:8]} ^ negQ_q;
         loHold_d = rdWord[7:0];
      end
   end

   always_ff @(posedge lnk.ck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         hiQ_q <= 8'h00;
         mskA_q <= 1'b1;
         started_q <= 1'b0;
         extra_q <= 1'b0;
         posQ_q <= 9'h000;
         loHold_q <= 8'h00;
      end else begin
         hiQ_q <= hiQ_d;
         mskA_q <= mskA_d;
         started_q <= started_d;
         extra_q <= extra_d;
         posQ_q <= posQ_d;
         loHold_q <= loHold_d;
      end
   end

   always_comb begin
      st_d = st_q;
      cyc_d = cyc_q;
      caTop_d = caTop_q;
      caMid_d = caMid_q;
      rnw_d = rnw_q;
      space_d = space_q;
      lin_d = lin_q;
      addr_d = addr_q;
      negQ_d = negQ_q;
      mem_d = mem_q;
      unique case (st_q)
         dps_pkg::DPS_DEV_CMD: begin
            cyc_d = cyc_q + 8'h01;
            if (cyc_q == 8'h00) begin
               rnw_d = word[`DPS_CA_RNW - `DPS_CA0_LSB];
               space_d = word[`DPS_CA_SPACE - `DPS_CA0_LSB];
               lin_d = word[`DPS_CA_LINEAR - `DPS_CA0_LSB];
               caTop_d = word[ROWW-1:0];
            end else if (cyc_q == 8'h01) begin
               caMid_d = word;
            end else begin
               addr_d = fullAddr[AW-1:0];
               st_d = dps_pkg::DPS_DEV_LAT;
            end
         end
         dps_pkg::DPS_DEV_LAT: begin
            cyc_d = cyc_q + 8'h01;
            if (cyc_q == (extra_q ? LAST2 : LAST1)) begin
               st_d = dps_pkg::DPS_DEV_DATA;
            end
         end
         dps_pkg::DPS_DEV_DATA: begin
            addr_d = addrNext;
            if (!rnw_q && !space_q) begin
               if (!mskA_q) begin
                  mem_d[addr_q][15:8] = hiQ_q;
               end
               if (!lnk.read_write_strobe) begin
                  mem_d[addr_q][7:0] = lnk.dq;
               end
            end
            if (rnw_q) begin
               negQ_d = {1'b0, loHold_q} ^ posQ_q;
            end
         end
         default: begin
            st_d = dps_pkg::DPS_DEV_CMD;
         end
      endcase
   end

   always_ff @(negedge lnk.ck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         st_q <= dps_pkg::DPS_DEV_CMD;
         cyc_q <= 8'h00;
         caTop_q <= '0;
         caMid_q <= 16'h0000;
         rnw_q <= 1'b0;
         space_q <= 1'b0;
         lin_q <= 1'b0;
         addr_q <= '0;
         negQ_q <= 9'h000;
      end else begin
         st_q <= st_d;
         cyc_q <= cyc_d;
         caTop_q <= caTop_d;
         caMid_q <= caMid_d;
         rnw_q <= rnw_d;
         space_q <= space_d;
         lin_q <= lin_d;
         addr_q <= addr_d;
         negQ_q <= negQ_d;
      end
   end

   // storage keeps its content across frames and resets
   always_ff @(negedge lnk.ck) begin
      mem_q <= mem_d;
   end

   // ddr outputs as xor of a rising and a falling flop: no clock in the data path
   always_comb begin
      lnk.dqD = posQ_q[7:0] ^ negQ_q[7:0];
      lnk.dqDOe = linkRst_n & rdData;
      lnk.rwdsD = (st_q == dps_pkg::DPS_DEV_CMD) ? latShown : (posQ_q[8] ^ negQ_q[8]);
      lnk.rwdsDOe = linkRst_n & ((st_q == dps_pkg::DPS_DEV_CMD) | rdData);
   end
endmodule

// ### logic/dps_host_end.sv
// dps_host_end: controller end of the ddr psram link, makes ck from clk
// assumes: HALF >= 4 so that two-flop pin samples settle inside a byte
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_host_end #(
   parameter int LAT = `DPS_LAT_CYC,
   parameter int HALF = `DPS_HALF_CLK
) (
   // link pins
   dps_link_if.host lnk,
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // request
   input wire logic start,
   input wire logic rnw,
   input wire logic regSpace,
   input wire logic linear,
   input wire logic [31:0] addr,
   input wire logic [15:0] nWords,
   input wire logic devReset,
   // write data
   input wire logic [15:0] wrData,
   input wire logic [1:0] wrMask,
   output logic wrTake,
   // read data and status
   output logic [15:0] rdData,
   output logic rdValid,
   output logic busy,
   output logic done,
   output logic extraLat
);
   localparam int PW = $clog2(HALF);
   localparam logic [PW-1:0] PH_TOG = PW'(HALF - 1);
   localparam logic [PW-1:0] PH_MID = PW'(HALF / 2 - 1);
   localparam logic [19:0] E_LAT = 20'(2 * LAT);
   localparam logic [19:0] E_CA = 20'(`DPS_CA_BYTES);
   localparam logic [19:0] E_CHK = 20'(`DPS_LAT_SAMPLE_EDGE);

   dps_pkg::dps_hst_st_t st_q, st_d;
   logic [PW-1:0] ph_q, ph_d;
   logic [19:0] edge_q, edge_d;
   logic [47:0] ca_q, ca_d;
   logic [15:0] n_q, n_d;
   logic [17:0] buf_q, buf_d;
   logic [15:0] rdData_q, rdData_d;
   logic [7:0] dqO_q, dqO_d, dqS1_q, dqS2_q;
   logic ck_q, ck_d, ckN_q, csN_q, csN_d, rnw_q, rnw_d;
   logic dqOe_q, dqOe_d, rwO_q, rwO_d, rwOe_q, rwOe_d, rwS1_q, rwS2_q;
   logic rdValid_q, rdValid_d, wrTake_q, wrTake_d, done_q, done_d;
   logic busy_q, extra_q, extra_d, rstPin_q;
   logic [47:0] caNew;
   logic [19:0] e0, e1, ePrev, eNext;

   assign caNew = {rnw, regSpace, linear, addr[31:`DPS_COL_BITS],
      `DPS_RSVD_BITS'(0), addr[`DPS_COL_BITS-1:0]};
   assign e0 = E_CA + E_LAT + (extra_q ? E_LAT : 20'h00000);
   assign e1 = e0 + {3'b000, n_q, 1'b0};
   assign ePrev = edge_q - 20'h00001;
   assign eNext = edge_q + 20'h00001;

   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      edge_d = edge_q;
      ca_d = ca_q;
      n_d = n_q;
      rnw_d = rnw_q;
      ck_d = ck_q;
      csN_d = csN_q;
      dqO_d = dqO_q;
      dqOe_d = dqOe_q;
      rwO_d = rwO_q;
      rwOe_d = rwOe_q;
      rdData_d = rdData_q;
      extra_d = extra_q;
      rdValid_d = 1'b0;
      wrTake_d = 1'b0;
      done_d = 1'b0;
      buf_d = wrTake_q ? {wrMask, wrData} : buf_q;
      unique case (st_q)
         dps_pkg::DPS_HST_IDLE: begin
            if (start) begin
               // byte 0 is put out again at the first mid point, then the shift starts
               ca_d = caNew;
               dqO_d = caNew[47:40];
               dqOe_d = 1'b1;
               csN_d = 1'b0;
               n_d = nWords;
               rnw_d = rnw;
               ph_d = '0;
               edge_d = 20'h00000;
               extra_d = 1'b0;
               st_d = dps_pkg::DPS_HST_RUN;
            end
         end
         dps_pkg::DPS_HST_RUN: begin
            ph_d = (ph_q == PH_TOG) ? PW'(0) : ph_q + 1'b1;
            if (ph_q == PH_TOG) begin
               // byte of the edge one half back, settled through two flops
               if (rnw_q && edge_q > e0 && edge_q <= e1) begin
                  if (!ePrev[0]) begin
                     rdData_d[15:8] = dqS2_q;
                  end else begin
                     rdData_d[7:0] = dqS2_q;
                     rdValid_d = 1'b1;
                  end
               end
               if (edge_q == E_CHK) begin
                  extra_d = rwS2_q;
               end
               if (edge_q == e1) begin
                  // last falling edge done: ck rests low, frame closes
                  csN_d = 1'b1;
                  dqOe_d = 1'b0;
                  rwOe_d = 1'b0;
                  st_d = dps_pkg::DPS_HST_STOP;
               end else begin
                  ck_d = ~ck_q;
                  edge_d = eNext;
                  wrTake_d = !rnw_q && edge_q[0] && eNext >= e0 && eNext < e1;
               end
            end
            if (ph_q == PH_MID) begin
               // new byte mid-way between edges: centred for the memory
               if (edge_q < E_CA) begin
                  dqO_d = ca_q[47:40];
                  ca_d = {ca_q[39:0], 8'h00};
               end else if (!rnw_q && edge_q >= e0 && edge_q < e1) begin
                  dqOe_d = 1'b1;
                  rwOe_d = 1'b1;
                  dqO_d = edge_q[0] ? buf_q[7:0] : buf_q[15:8];
                  rwO_d = edge_q[0] ? buf_q[16] : buf_q[17];
               end else begin
                  dqOe_d = 1'b0;
                  rwOe_d = 1'b0;
               end
            end
         end
         dps_pkg::DPS_HST_STOP: begin
            ph_d = ph_q + 1'b1;
            if (ph_q == PH_TOG) begin
               done_d = 1'b1;
               st_d = dps_pkg::DPS_HST_IDLE;
            end
         end
         default: begin
            st_d = dps_pkg::DPS_HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= dps_pkg::DPS_HST_IDLE;
         ph_q <= '0;
         edge_q <= 20'h00000;
         ca_q <= 48'h000000000000;
         n_q <= 16'h0000;
         rnw_q <= 1'b0;
         ck_q <= 1'b0;
         ckN_q <= 1'b1;
         csN_q <= 1'b1;
         dqO_q <= 8'h00;
         dqOe_q <= 1'b0;
         rwO_q <= 1'b0;
         rwOe_q <= 1'b0;
         dqS1_q <= 8'h00;
         dqS2_q <= 8'h00;
         rwS1_q <= 1'b0;
         rwS2_q <= 1'b0;
         rdData_q <= 16'h0000;
         rdValid_q <= 1'b0;
         wrTake_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
         extra_q <= 1'b0;
         buf_q <= 18'h00000;
         rstPin_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         edge_q <= edge_d;
         ca_q <= ca_d;
         n_q <= n_d;
         rnw_q <= rnw_d;
         ck_q <= ck_d;
         ckN_q <= ~ck_d;
         csN_q <= csN_d;
         dqO_q <= dqO_d;
         dqOe_q <= dqOe_d;
         rwO_q <= rwO_d;
         rwOe_q <= rwOe_d;
         dqS1_q <= lnk.dq;
         dqS2_q <= dqS1_q;
         rwS1_q <= lnk.read_write_strobe;
         rwS2_q <= rwS1_q;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
         wrTake_q <= wrTake_d;
         done_q <= done_d;
         busy_q <= (st_d != dps_pkg::DPS_HST_IDLE);
         extra_q <= extra_d;
         buf_q <= buf_d;
         rstPin_q <= ~devReset;
      end
   end

   assign lnk.ck = ck_q;
   assign lnk.ckN = ckN_q;
   assign lnk.csN = csN_q;
   assign lnk.hwRstN = rstPin_q;
   assign lnk.dqH = dqO_q;
   assign lnk.dqHOe = dqOe_q;
   assign lnk.rwdsH = rwO_q;
   assign lnk.rwdsHOe = rwOe_q;
   assign wrTake = wrTake_q;
   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign busy = busy_q;
   assign done = done_q;
   assign extraLat = extra_q;
endmodule

// ### dv/dps_link_properties.sv
// dps_link_properties: timing checks on the link pins between the two ends
// assumes: sampled on the host system clock, ck made from it by the host
`timescale 1ns/1ps
module dps_link_properties #(
   parameter int LAT = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // link pins
   input wire logic ck,
   input wire logic csN,
   input wire logic hwRstN,
   input wire logic dqHOe,
   input wire logic dqDOe,
   input wire logic read_write_strobe,
   input wire logic rwdsD,
   input wire logic rwdsDOe,
   // strap
   input wire logic dualDie
);
   logic ck_q;
   logic [15:0] riseCnt_q;
   logic [15:0] riseCnt_d;
   logic extra_q;
   logic extra_d;
   logic [15:0] firstData;
   // ck rises counted one clk late; saturates so long bursts cannot wrap
   always_comb begin
      riseCnt_d = riseCnt_q;
      extra_d = extra_q;
      if (csN) begin
         riseCnt_d = 16'h0000;
      end else if (ck && !ck_q && riseCnt_q != 16'hffff) begin
         riseCnt_d = riseCnt_q + 16'h0001;
      end
      if (!csN && riseCnt_q == 16'h0002) begin
         extra_d = read_write_strobe;
      end
   end
   assign firstData = extra_q ? 16'(3 + 2 * LAT) : 16'(3 + LAT);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ck_q <= 1'b0;
         riseCnt_q <= 16'h0000;
         extra_q <= 1'b0;
      end else begin
         ck_q <= ck;
         riseCnt_q <= riseCnt_d;
         extra_q <= extra_d;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_reset_float;
      !hwRstN |-> !dqDOe && !rwdsDOe;
   endproperty
   a_reset_float: assert property (p_reset_float)
      else $error("memory drives the link while held in reset");
   property p_idle_float;
      csN |-> !dqDOe && !rwdsDOe;
   endproperty
   a_idle_float: assert property (p_idle_float)
      else $error("memory drives the link outside a frame");
   property p_clk_idle;
      csN |-> !ck;
   endproperty
   a_clk_idle: assert property (p_clk_idle)
      else $error("link clock not parked low between frames");
   property p_ca_strobe;
      !csN && riseCnt_q inside {16'h0001, 16'h0002} |-> rwdsDOe && !dqDOe;
   endproperty
   a_ca_strobe: assert property (p_ca_strobe)
      else $error("strobe not driven by memory during command bytes");
   property p_ca_steady;
      !csN && riseCnt_q == 16'h0002 && $past(riseCnt_q) == 16'h0002 |-> $stable(read_write_strobe);
   endproperty
   a_ca_steady: assert property (p_ca_steady)
      else $error("latency flag changed inside the command phase");
   property p_dual_die;
      !csN && dualDie && riseCnt_q == 16'h0002 |-> read_write_strobe;
   endproperty
   a_dual_die: assert property (p_dual_die)
      else $error("dual die strap but no extra latency flagged");
   property p_ca_host;
      !csN && riseCnt_q inside {16'h0001, 16'h0002} |-> dqHOe;
   endproperty
   a_ca_host: assert property (p_ca_host)
      else $error("host not driving command bytes");
   property p_data_start;
      $rose(dqDOe) |-> riseCnt_q == firstData && !ck;
   endproperty
   a_data_start: assert property (p_data_start)
      else $error("read data turned on at the wrong cycle");
   property p_read_strobe;
      dqDOe && $past(dqDOe, 5) |-> rwdsDOe && rwdsD == ck;
   endproperty
   a_read_strobe: assert property (p_read_strobe)
      else $error("read strobe not aligned with link clock");
   c_plain: cover property ($rose(dqDOe) && !extra_q);
   c_extra: cover property ($rose(dqDOe) && extra_q);
   c_hwrst: cover property ($fell(hwRstN));
endmodule

// ### dv/ddr_psram_slave_port_test.sv
// ddr_psram_slave_port_test: host end and memory end joined, checked end to end
// assumes: logic/ files compiled first, dps_map.svh on the include path
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin nErrors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ddr_psram_slave_port_test;
   localparam int LAT = 6;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0;
   logic rnw = 1'b0;
   logic regSpace = 1'b0;
   logic linear = 1'b0;
   logic devReset = 1'b0;
   logic refreshReq = 1'b0;
   logic dualDie = 1'b0;
   logic fill = 1'b0;
   logic [31:0] addr = 32'h00000000;
   logic [15:0] nWords = 16'h0000;
   logic [15:0] wrData = 16'h0000;
   logic [1:0] wrMask = 2'h0;
   logic wrTake, rdValid, hBusy, dBusy, done, extraLat;
   logic [15:0] rdData;
   logic [15:0] mem [1024];
   logic [31:0] seed = 32'h0000fa67;
   logic [31:0] r;
   logic [31:0] rv;
   int nErrors = 0;
   int checks = 0;
   int cycles = 0;
   int wIdx = 0;
   int rIdx = 0;
   dps_link_if lnk ();
   always #2.5 clk = ~clk;
   dps_host_end #(.LAT(LAT), .HALF(4)) dps_host_end_inst (.lnk(lnk.host), .clk(clk),
      .arst_n(arst_n), .start(start), .rnw(rnw), .regSpace(regSpace), .linear(linear),
      .addr(addr), .nWords(nWords), .devReset(devReset), .wrData(wrData), .wrMask(wrMask),
      .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .busy(hBusy), .done(done),
      .extraLat(extraLat));
   dps_dev_end #(.AW(10), .WRAP_LOG2(4), .LAT(LAT)) dps_dev_end_inst (.lnk(lnk.dev),
      .clk(clk), .arst_n(arst_n), .refreshReq(refreshReq), .dualDie(dualDie), .busy(dBusy));
   dps_link_properties #(.LAT(LAT)) dps_link_properties_inst (.clk(clk), .arst_n(arst_n),
      .ck(lnk.ck), .csN(lnk.csN), .hwRstN(lnk.hwRstN), .dqHOe(lnk.dqHOe),
      .dqDOe(lnk.dqDOe), .read_write_strobe(lnk.read_write_strobe), .rwdsD(lnk.rwdsD), .rwdsDOe(lnk.rwdsDOe),
      .dualDie(dualDie));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // word order of a burst: linear wraps at the die top, wrapped stays in 16 words
   function automatic logic [9:0] seqAddr(input int i);
      if (linear) return addr[9:0] + 10'(i);
      return {addr[9:4], addr[3:0] + 4'(i)};
   endfunction
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks, nErrors);
      if (nErrors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (wrTake) begin
         if (!regSpace && !wrMask[1]) mem[seqAddr(wIdx)][15:8] = wrData[15:8];
         if (!regSpace && !wrMask[0]) mem[seqAddr(wIdx)][7:0] = wrData[7:0];
         wIdx++;
         r = rnd();
         wrData <= r[15:0];
         wrMask <= fill ? 2'h0 : r[17:16];
      end
      if (rdValid) begin
         `CHK(rdData, regSpace ? 16'h0000 : mem[seqAddr(rIdx)])
         rIdx++;
      end
   end
   always @(negedge lnk.csN) begin
      @(posedge lnk.ck);
      `CHK(lnk.dq, {rnw, regSpace, linear, 5'h00})
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         nErrors++;
         complete_run();
      end
   end
   task automatic xfer(input logic rd, input logic rg, input logic ln, input logic [9:0] a,
      input logic [15:0] n, input logic ex);
      int w;
      rnw <= rd;
      regSpace <= rg;
      linear <= ln;
      addr <= {22'h000000, a};
      nWords <= n;
      start <= 1'b1;
      wIdx = 0;
      rIdx = 0;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK({hBusy, dBusy}, 2'b11)
      w = 0;
      // a full-array linear burst needs about 8300 system clocks
      while (done !== 1'b1 && w < 12000) begin
         @(negedge clk);
         w++;
      end
      repeat (2) @(negedge clk);
      `CHK(w < 12000, 1'b1)
      `CHK({hBusy, dBusy}, 2'b00)
      `CHK(rd ? rIdx : wIdx, int'(n))
      if (ex) `CHK(extraLat, dualDie | refreshReq)
      @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      fill <= 1'b1;
      xfer(1'b0, 1'b0, 1'b1, 10'h200, 16'd1024, 1'b0);
      fill <= 1'b0;
      xfer(1'b1, 1'b0, 1'b1, 10'h3fc, 16'd8, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, 10'h0bd, 16'd16, 1'b1);
      xfer(1'b1, 1'b1, 1'b0, 10'h000, 16'd4, 1'b1);
      xfer(1'b0, 1'b1, 1'b1, 10'h010, 16'd4, 1'b0);
      xfer(1'b1, 1'b0, 1'b1, 10'h00e, 16'd6, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, 10'h000, 16'd0, 1'b1);
      // flag inputs settle over the write so the read sees them synced
      for (int k = 0; k < 14; k++) begin
         rv = rnd();
         refreshReq <= rv[0];
         dualDie <= rv[1];
         xfer(1'b0, 1'b0, rv[2], rv[13:4], {12'h000, rv[19:16]} + 16'd1, 1'b0);
         xfer(1'b1, 1'b0, rv[3], rv[13:4], 16'd20, 1'b1);
      end
      // the reset clears the synced refresh flag and no write follows to resync it
      refreshReq <= 1'b0;
      devReset <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(lnk.hwRstN, 1'b0)
      `CHK(lnk.dqDOe | lnk.rwdsDOe, 1'b0)
      devReset <= 1'b0;
      repeat (3) @(posedge clk);
      xfer(1'b1, 1'b0, 1'b1, 10'h200, 16'd12, 1'b1);
      complete_run();
   end
endmodule
